// ==== dv/hps_link_asserts.sv ====
// Concurrent checks on the ports of the polled slave link.
`timescale 1ns/1ns
module hps_link_asserts (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic RTS,
  input wire logic IRQ
);
  logic [4:0] rx_quiet;

  // Cycles since the receive line was last low, saturating.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rx_quiet <= 5'h00;
    else if (!RXD)
      rx_quiet <= 5'h00;
    else if (rx_quiet != 5'h1F)
      rx_quiet <= rx_quiet + 5'h01;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_WR_ANSWER: assert property (AWVALID && AWREADY && WVALID && WREADY
    |=> !BVALID ##1 BVALID) else $error("write answer off time");
  AST_RD_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped");
  AST_AR_REFUSE: assert property (RVALID |-> !ARREADY)
    else $error("read taken while answering");
  AST_AW_REFUSE: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answering");
  AST_TX_QUIET: assert property ($fell(TXD) |-> rx_quiet > 5'h08)
    else $error("transmit started during reception");
  AST_RTS_IDLE: assert property ($fell(RTS) |-> TXD && $past(TXD, 8))
    else $error("request to send dropped mid character");
  AST_RTS_LEAD: assert property ($rose(RTS) |-> TXD ##1 TXD)
    else $error("transmit with request to send");
  AST_RESET_IDLE: assert property ($rose(RST_N) |-> TXD && !RTS && !IRQ)
    else $error("outputs not idle after reset");

  cover property (ARVALID && ARREADY);
  cover property ($rose(RTS));
  cover property ($fell(IRQ));
endmodule : hps_link_asserts

bind hps_link hps_link_asserts i_hps_link_asserts (.CLK, .RST_N, .AWVALID,
  .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY,
  .RDATA, .RVALID, .RREADY, .RXD, .TXD, .RTS, .IRQ);

// ==== dv/hps_link_tb.sv ====
// Self-checking testbench of the polled slave link.
`timescale 1ns/1ns
module hps_link_tb
  import hps_pkg::*;
;
  logic CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, RXD, CTS;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXD, RTS, DRV_EN, IRQ;
  logic [1:0] BRESP, RRESP, rs;
  logic [7:0] b;
  int error_cnt, compares, cyc, t0, lows;

`define CHK(a, e) if ((a) !== (e)) fail(32'(a), 32'(e)); else compares++;

  hps_link #(.P_CYC_PER_MS(20)) i_hps_link (.CLK, .RST_N, .AWADDR, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .RXD,
    .CTS, .TXD, .RTS, .DRV_EN, .IRQ);
  hps_master_model i_hps_master_model (.clk(CLK), .ser_out(RXD),
    .ser_in(TXD), .rts(RTS), .cts(CTS));

  always #25 CLK = ~CLK;

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic fail(input logic [31:0] a, input logic [31:0] e);
    compares++;
    error_cnt++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
  endtask : fail

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    do
    begin
      @(posedge CLK);
      if (AWREADY)
        AWVALID <= 1'h0;
      if (WREADY)
        WVALID <= 1'h0;
    end
    while (!BVALID);
    BREADY <= 1'h1;
    @(posedge CLK);
    BREADY <= 1'h0;
    `CHK(BRESP, 2'h0)
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'h1;
    do
    begin
      @(posedge CLK);
      if (ARREADY)
        ARVALID <= 1'h0;
    end
    while (!RVALID);
    RREADY <= 1'h1;
    @(posedge CLK);
    RREADY <= 1'h0;
    d = RDATA;
    r = RRESP;
  endtask : axr

  task automatic send_poll(input logic [7:0] s);
    logic [7:0] f [5];
    f = '{8'h01, CMD_POLL, s, 8'h00, 8'(8'h00 - 8'h01 - CMD_POLL - s)};
    foreach (f[i])
      i_hps_master_model.send_byte(f[i]);
  endtask : send_poll

  task automatic t_regs();
    axr(OFF_CTRL, rd, rs);
    `CHK(rd, 32'h0000_0106)
    axr(OFF_ADDR, rd, rs);
    `CHK(rd, 32'h0000_0001)
    axw(OFF_ADDR, 32'h0000_00FF);
    axr(OFF_ADDR, rd, rs);
    `CHK(rd, 32'h0000_0001)
    axr(12'h02C, rd, rs);
    `CHK({rs, rd}, 34'h2_0000_0000)
    $display("regs test done");
  endtask : t_regs

  task automatic t_timeout();
    axw(OFF_PTO, 32'h0000_0002);
    axw(OFF_REQ, 32'h0000_00AA);
    repeat (900) @(posedge CLK);
    `CHK(IRQ, 1'h0)
    axw(OFF_MASK, 32'h0000_0004);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'h1)
    axr(OFF_STAT, rd, rs);
    `CHK(rd, 32'h0000_0004)
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'h0)
    axr(OFF_REQ, rd, rs);
    `CHK(rd[8], 1'h0)
    $display("timeout test done");
  endtask : t_timeout

  task automatic t_silent();
    axw(OFF_CTRL, 32'h0000_0057);
    send_poll(8'h00);
    lows = 0;
    repeat (2000) @(posedge CLK)
      lows += int'(TXD !== 1'h1 || DRV_EN !== 1'h0);
    `CHK(lows, 0)
    $display("silent poll test done");
  endtask : t_silent

  task automatic t_modem();
    logic [7:0] e [5];
    e = '{8'h01, CMD_EOT, 8'h00, 8'h00, 8'(8'h00 - 8'h01 - CMD_EOT - 8'h00)};
    axw(OFF_CTRL, 32'h0000_0027);
    axw(OFF_PRE, 32'h0000_001E);
    axw(OFF_RSND, 32'h0000_0001);
    axw(OFF_ROFF, 32'h0000_0001);
    send_poll(8'h00);
    t0 = cyc - 512;
    while (!RTS)
      @(posedge CLK);
    `CHK(cyc - t0 >= 600, 1'h1)
    t0 = cyc;
    while (TXD)
      @(posedge CLK);
    `CHK(cyc - t0 >= 400, 1'h1)
    foreach (e[i])
    begin
      i_hps_master_model.recv_byte(b);
      `CHK(b, e[i])
    end
    repeat (300) @(posedge CLK);
    `CHK(RTS, 1'h1)
    repeat (500) @(posedge CLK);
    `CHK(RTS, 1'h0)
    $display("modem reply test done");
  endtask : t_modem

  task automatic t_nopto();
    axw(OFF_PTO, 32'h0000_0000);
    axw(OFF_REQ, 32'h0000_0055);
    repeat (900) @(posedge CLK);
    axr(OFF_REQ, rd, rs);
    `CHK(rd[8], 1'h1)
    `CHK(IRQ, 1'h0)
    $display("timeout off test done");
  endtask : t_nopto

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    CLK = 1'h0;
    RST_N = 1'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 12'h000;
    ARADDR = 12'h000;
    WDATA = 32'h0000_0000;
    WSTRB = 4'hF;
    repeat (2) @(posedge CLK);
    RST_N <= 1'h1;
    repeat (4) @(posedge CLK);
    t_regs();
    t_timeout();
    t_silent();
    t_modem();
    t_nopto();
    finish_test();
  end
endmodule : hps_link_tb

// ==== dv/hps_master_model.sv ====
// Polling master station model on the serial line.
`timescale 1ns/1ns
module hps_master_model #(
  parameter int BIT_CYC = 512,
  parameter int CTS_LAG = 4
)
(
  input wire logic clk,
  output logic ser_out,
  input wire logic ser_in,
  input wire logic rts,
  output logic cts
);
  logic [7:0] lag;

  initial ser_out = 1'h1;
  initial lag = 8'h00;

  // The modem answers a raised request to send after a lag.
  always @(posedge clk)
    lag <= {lag[6:0], rts};
  assign cts = lag[CTS_LAG-1];

  // One character, start bit, eight bits low first, stop bit.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      ser_out <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b);
    while (ser_in)
      @(posedge clk);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      if (i < 8)
        b[i] = ser_in;
    end
  endtask : recv_byte
endmodule : hps_master_model

// ==== verilog/hps_link.sv ====
// Polled half-duplex slave link controller with an AXI4-Lite register file.
//
// Function
// [R1] The character rate is one of 300 to 38400 baud, 19200 by default, with no or even parity.
// [R2] The station address is 0 to 254, 1 by default, and 255 is never taken since it means broadcast.
// [R3] The line mode is plain, plain on a 485 multidrop bus, or RTS/CTS modem, plain by default.
// [R4] With empty-poll silence on, a poll finding no queued message gets no answer at all.
// [R5] With duplicate detection on, a repeated copy of the last message is dropped; the code drops only repeats of frames addressed to the station.
// [R6] A queued outgoing message waits at most the poll timeout for a poll, else it is flagged as failed.
// [R7] A poll timeout of zero turns the timeout off.
// [R8] In modem mode RTS stays high for the off delay, in 20 ms units, after the last character.
// [R9] In modem mode RTS rises, the send delay in 20 ms units passes, and only then CTS is checked.
// [R10] The master resends an unanswered packet up to its retry count, 0 to 255, 3 by default.
// [R11] In plain modes the pre-transmit delay in 1 ms units passes before any transmission.
// [R12] In modem mode at least the pre-transmit delay passes from the last received character to RTS.
// [R13] The slave transmits only in answer to a frame addressed to it, never unasked.
// [R14] Each frame carries a CRC or a block_check_character, and a frame failing it is rejected.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module hps_link
  import hps_pkg::*;
#(
  parameter int P_CYC_PER_MS = CYC_PER_MS
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic RXD,
  input wire logic CTS,
  output logic TXD,
  output logic RTS,
  output logic DRV_EN,
  output logic IRQ
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_EVAL = 8'h02,
    ST_TURN = 8'h04,
    ST_RTSW = 8'h08,
    ST_CTSW = 8'h10,
    ST_SEND = 8'h20,
    ST_DRAIN = 8'h40,
    ST_RTSOFF = 8'h80
  } hps_state_t;

  typedef struct packed {
    logic rxd_m;
    logic rxd_s;
    logic cts_m;
    logic cts_s;
    logic awready;
    logic wready;
    logic bvalid;
    logic bresp_err;
    logic arready;
    logic rvalid;
    logic rresp_err;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic irq;
    logic [8:0] ctrl;
    logic [7:0] addr;
    logic [15:0] poll_to;
    logic [15:0] rts_off;
    logic [15:0] rts_send;
    logic [15:0] pre_tx;
    logic [4:0] mask;
    logic [4:0] status;
    logic q_have;
    logic q_polled;
    logic [7:0] q_data;
    logic [7:0] q_seq;
    logic [15:0] pto;
    logic [7:0] rx_data;
    logic [7:0] last_seq;
    logic last_ok;
    hps_state_t st;
    logic [2:0] ridx;
    logic rbad;
    logic [21:0] gap;
    logic [15:0] racc;
    logic [5:0][7:0] rbuf;
    logic [3:0][7:0] tbuf;
    logic [2:0] tidx;
    logic [15:0] tacc;
    logic tx_valid;
    logic [7:0] tx_data;
    logic rts;
    logic drv_en;
    logic reply_req;
    logic [19:0] t_cyc;
    logic [15:0] t_left;
    logic t_u20;
    logic [19:0] ms_cyc;
    logic [4:0] ms20;
    logic tick20;
  } hps_link_t;

  localparam logic [19:0] UNIT1 = 20'(P_CYC_PER_MS);
  localparam logic [19:0] UNIT20 = 20'(TICK20_MS * P_CYC_PER_MS);

  logic [1:0] rst_sync;
  logic rst_n;
  hps_link_t r;
  hps_link_t next_r;
  hps_ser_if ser();

  // ****************************************
  // Reset release and character engine
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  hps_uart u_uart (
    .clk(CLK),
    .rst_n(rst_n),
    .ser(ser.phy)
  );

  assign ser.div = hps_baud_div(r.ctrl[2:0]);
  assign ser.par_en = r.ctrl[CTRL_PAR];
  assign ser.tx_valid = r.tx_valid;
  assign ser.tx_data = r.tx_data;
  assign ser.rxd = r.rxd_s;

  // ****************************************
  // Register decode
  // ****************************************
  function automatic logic reg_mapped(input logic [11:0] a);
    return a[1:0] == 2'b00 && a <= OFF_LINE;
  endfunction : reg_mapped

  function automatic logic [31:0] reg_value(input logic [11:0] a);
    case (a)
      OFF_CTRL: return {23'h0, r.ctrl};
      OFF_ADDR: return {24'h0, r.addr};
      OFF_PTO: return {16'h0, r.poll_to};
      OFF_ROFF: return {16'h0, r.rts_off};
      OFF_RSND: return {16'h0, r.rts_send};
      OFF_PRE: return {16'h0, r.pre_tx};
      OFF_REQ: return {23'h0, r.q_have, r.q_data};
      OFF_RXD: return {24'h0, r.rx_data};
      OFF_STAT: return {27'h0, r.status};
      OFF_MASK: return {27'h0, r.mask};
      OFF_LINE: return {29'h0, r.q_have, r.cts_s, r.rts};
      default: return 32'h0000_0000;
    endcase
  endfunction : reg_value

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        m[i*8 +: 8] = d[i*8 +: 8];
    return m;
  endfunction : merge

  // ****************************************
  // Next state
  // ****************************************
  logic [31:0] wv;
  logic [4:0] set;
  logic [4:0] clr;
  logic [19:0] unit;
  logic t_done;
  logic modem;
  logic crc;
  logic [2:0] flen;
  logic mine;
  logic reply;
  logic [7:0] rtype;

  always_comb
  begin
    next_r = r;
    wv = 32'h0000_0000;
    set = 5'h00;
    clr = 5'h00;
    reply = 1'b0;
    rtype = CMD_ACK;
    modem = hps_mode_t'(r.ctrl[5:4]) == HPS_MODE_MODEM; // [R3]
    crc = r.ctrl[CTRL_CRC];
    flen = crc ? 3'h6 : 3'h5;
    mine = r.rbuf[0] == r.addr;
    next_r.rxd_m = RXD;
    next_r.rxd_s = r.rxd_m;
    next_r.cts_m = CTS;
    next_r.cts_s = r.cts_m;
    next_r.tx_valid = 1'b0;
    next_r.tick20 = 1'b0;
    if (r.ms_cyc == UNIT1 - 20'h0_0001)
    begin
      next_r.ms_cyc = 20'h0_0000;
      next_r.ms20 = r.ms20 + 5'h01;
      if (r.ms20 == 5'(TICK20_MS - 1))
      begin
        next_r.ms20 = 5'h00;
        next_r.tick20 = 1'b1;
      end
    end
    else
      next_r.ms_cyc = r.ms_cyc + 20'h0_0001;
    unit = r.t_u20 ? UNIT20 : UNIT1;
    t_done = r.t_left == 16'h0000;
    if (!t_done)
    begin
      next_r.t_cyc = r.t_cyc + 20'h0_0001;
      if (r.t_cyc == unit - 20'h0_0001)
      begin
        next_r.t_cyc = 20'h0_0000;
        next_r.t_left = r.t_left - 16'h0001;
      end
    end
    // Poll timeout runs while a queued message is still unpolled.
    if (r.q_have && !r.q_polled)
    begin
      if (r.tick20)
        next_r.pto = r.pto + 16'h0001;
      if (r.poll_to != 16'h0000 && r.pto >= r.poll_to) // [R7]
      begin
        next_r.q_have = 1'b0; // [R6]
        set[ST_PTO] = 1'b1;
      end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    if (AWVALID && r.awready)
    begin
      next_r.aw_have = 1'b1;
      next_r.awaddr = AWADDR;
    end
    if (WVALID && r.wready)
    begin
      next_r.w_have = 1'b1;
      next_r.wdata = WDATA;
      next_r.wstrb = WSTRB;
    end
    if (BREADY && r.bvalid)
      next_r.bvalid = 1'b0;
    if (r.aw_have && r.w_have && !r.bvalid)
    begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp_err = !reg_mapped(r.awaddr);
      wv = merge(reg_value(r.awaddr), r.wdata, r.wstrb);
      case (r.awaddr)
        OFF_CTRL: next_r.ctrl = wv[8:0]; // [R1] [R3]
        OFF_ADDR:
          if (wv[7:0] != ADDR_BCAST)
            next_r.addr = wv[7:0]; // [R2]
        OFF_PTO: next_r.poll_to = wv[15:0];
        OFF_ROFF: next_r.rts_off = wv[15:0];
        OFF_RSND: next_r.rts_send = wv[15:0];
        OFF_PRE: next_r.pre_tx = wv[15:0];
        OFF_REQ:
          if (r.wstrb[0] && !r.q_polled)
          begin
            next_r.q_have = 1'b1;
            next_r.q_data = wv[7:0];
            next_r.pto = 16'h0000;
          end
        OFF_MASK: next_r.mask = wv[4:0];
        default: next_r.mask = next_r.mask;
      endcase
    end
    next_r.awready = !next_r.aw_have && !next_r.bvalid;
    next_r.wready = !next_r.w_have && !next_r.bvalid;
    if (RREADY && r.rvalid)
      next_r.rvalid = 1'b0;
    if (ARVALID && r.arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = reg_value(ARADDR);
      next_r.rresp_err = !reg_mapped(ARADDR);
      if (ARADDR == OFF_STAT)
        clr = r.status;
    end
    next_r.arready = !next_r.rvalid;

    // ****************************************
    // Link sequencer
    // ****************************************
    case (r.st)
      ST_IDLE:
        if (ser.rx_valid)
        begin
          next_r.rbuf[r.ridx] = ser.rx_data;
          next_r.racc = hps_chk_next(r.racc, ser.rx_data, crc); // [R14]
          next_r.rbad = r.rbad | ser.rx_err;
          next_r.gap = 22'h00_0000;
          next_r.ridx = r.ridx + 3'h1;
          if (r.ridx == flen - 3'h1)
            next_r.st = ST_EVAL;
        end
        else if (r.ridx != 3'h0)
        begin
          next_r.gap = r.gap + 22'h00_0001;
          if (r.gap[21:9] == ser.div[12:0])
          begin
            next_r.ridx = 3'h0;
            next_r.racc = 16'h0000;
            next_r.rbad = 1'b0;
          end
        end
      ST_EVAL:
      begin
        next_r.st = ST_IDLE;
        next_r.ridx = 3'h0;
        next_r.racc = 16'h0000;
        next_r.rbad = 1'b0;
        if (r.rbad || r.racc != 16'h0000)
          set[ST_BAD] = 1'b1; // [R14]
        else if (r.rbuf[1] == CMD_POLL && mine)
        begin
          if (r.q_have)
          begin
            reply = 1'b1;
            rtype = CMD_DAT;
            next_r.q_polled = 1'b1;
            next_r.reply_req = 1'b1;
          end
          else
          begin
            reply = !r.ctrl[CTRL_SIL]; // [R4]
            rtype = CMD_EOT;
          end
        end
        else if (r.rbuf[1] == CMD_DAT && (mine || r.rbuf[0] == ADDR_BCAST))
        begin
          reply = mine; // [R13]
          if (mine && r.ctrl[CTRL_DUP] && r.last_ok &&
              r.rbuf[2] == r.last_seq)
            set[ST_DUP] = 1'b1; // [R5]
          else
          begin
            set[ST_RX] = 1'b1;
            next_r.rx_data = r.rbuf[3];
            next_r.last_seq = r.rbuf[2];
            next_r.last_ok = mine;
          end
        end
        if (reply)
        begin
          next_r.tbuf = rtype == CMD_DAT ?
                        {r.q_data, r.q_seq, CMD_DAT, r.addr} :
                        {8'h00, r.rbuf[2], rtype, r.addr};
          next_r.tidx = 3'h0;
          next_r.tacc = 16'h0000;
          next_r.st = ST_TURN;
          next_r.t_left = r.pre_tx; // [R11] [R12]
          next_r.t_cyc = 20'h0_0000;
          next_r.t_u20 = 1'b0;
        end
      end
      ST_TURN:
        if (t_done)
        begin
          if (modem)
          begin
            next_r.rts = 1'b1; // [R9]
            next_r.st = ST_RTSW;
            next_r.t_left = r.rts_send;
            next_r.t_cyc = 20'h0_0000;
            next_r.t_u20 = 1'b1;
          end
          else
          begin
            next_r.drv_en = hps_mode_t'(r.ctrl[5:4]) == HPS_MODE_485;
            next_r.st = ST_SEND;
          end
        end
      ST_RTSW:
        if (t_done)
          next_r.st = ST_CTSW;
      ST_CTSW:
        if (r.cts_s)
          next_r.st = ST_SEND; // [R9]
      ST_SEND:
        if (!r.tx_valid && ser.tx_idle)
        begin
          next_r.tx_valid = 1'b1;
          if (r.tidx < 3'h4)
          begin
            next_r.tx_data = r.tbuf[r.tidx[1:0]];
            next_r.tacc = hps_chk_next(r.tacc, r.tbuf[r.tidx[1:0]], crc);
          end
          else if (crc)
            next_r.tx_data = r.tidx == 3'h4 ? r.tacc[7:0] : r.tacc[15:8];
          else
            next_r.tx_data = 8'h00 - r.tacc[7:0]; // [R14]
          next_r.tidx = r.tidx + 3'h1;
          if (r.tidx == flen - 3'h1)
            next_r.st = ST_DRAIN;
        end
      ST_DRAIN:
        if (!r.tx_valid && ser.tx_idle)
        begin
          set[ST_SENT] = 1'b1;
          if (r.reply_req)
          begin
            next_r.q_have = 1'b0;
            next_r.q_polled = 1'b0;
            next_r.q_seq = r.q_seq + 8'h01;
          end
          next_r.reply_req = 1'b0;
          next_r.drv_en = 1'b0;
          next_r.st = ST_IDLE;
          if (modem)
          begin
            next_r.st = ST_RTSOFF; // [R8]
            next_r.t_left = r.rts_off;
            next_r.t_cyc = 20'h0_0000;
            next_r.t_u20 = 1'b1;
          end
        end
      ST_RTSOFF:
        if (t_done)
        begin
          next_r.rts = 1'b0; // [R8]
          next_r.st = ST_IDLE;
        end
      default: next_r.st = ST_IDLE;
    endcase

    next_r.status = (r.status & ~clr) | set;
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.rxd_m <= 1'b1;
      r.rxd_s <= 1'b1;
      r.ctrl <= CTRL_RESET;
      r.addr <= ADDR_RESET;
      r.st <= ST_IDLE;
    end
    else
      r <= next_r;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign AWREADY = r.awready;
  assign WREADY = r.wready;
  assign BVALID = r.bvalid;
  assign BRESP = {r.bresp_err, 1'b0};
  assign ARREADY = r.arready;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = {r.rresp_err, 1'b0};
  assign TXD = ser.txd;
  assign RTS = r.rts;
  assign DRV_EN = r.drv_en;
  assign IRQ = r.irq;

endmodule : hps_link

// ==== verilog/hps_pkg.sv ====
// Package: constants, types and shared functions of the polled slave link.
package hps_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 50;
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int TICK20_MS = 20;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_BASE = 300;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_PTO = 12'h008;
  localparam logic [11:0] OFF_ROFF = 12'h00C;
  localparam logic [11:0] OFF_RSND = 12'h010;
  localparam logic [11:0] OFF_PRE = 12'h014;
  localparam logic [11:0] OFF_REQ = 12'h018;
  localparam logic [11:0] OFF_RXD = 12'h01C;
  localparam logic [11:0] OFF_STAT = 12'h020;
  localparam logic [11:0] OFF_MASK = 12'h024;
  localparam logic [11:0] OFF_LINE = 12'h028;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_PAR = 3;
  localparam int CTRL_SIL = 6;
  localparam int CTRL_DUP = 7;
  localparam int CTRL_CRC = 8;
  localparam logic [8:0] CTRL_RESET = 9'h106;
  localparam logic [7:0] ADDR_RESET = 8'h01;
  localparam logic [7:0] ADDR_BCAST = 8'hFF;
  localparam int ST_RX = 0;
  localparam int ST_SENT = 1;
  localparam int ST_PTO = 2;
  localparam int ST_BAD = 3;
  localparam int ST_DUP = 4;
  localparam logic [7:0] CMD_POLL = 8'h05;
  localparam logic [7:0] CMD_DAT = 8'h10;
  localparam logic [7:0] CMD_ACK = 8'h06;
  localparam logic [7:0] CMD_EOT = 8'h04;

  typedef enum logic [1:0] {
    HPS_MODE_PLAIN = 2'h0,
    HPS_MODE_485 = 2'h1,
    HPS_MODE_MODEM = 2'h2
  } hps_mode_t;

  // Oversample divisor for rate index 0..7 (300 up to 38400 baud).
  function automatic logic [15:0] hps_baud_div(input logic [2:0] sel);
    return 16'(CLK_HZ / (OVERSAMPLE * (BAUD_BASE << sel)));
  endfunction : hps_baud_div

  // One byte into a CRC-16 or a block check sum.
  function automatic logic [15:0] hps_chk_next(input logic [15:0] acc,
      input logic [7:0] b, input logic crc);
    logic [15:0] c;
    c = acc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return crc ? c : {8'h00, 8'(acc[7:0] + b)};
  endfunction : hps_chk_next

endpackage : hps_pkg

// ==== verilog/hps_ser_if.sv ====
// Interface between the link controller and its character engine.
`timescale 1ns/1ns
interface hps_ser_if;
  logic [15:0] div;
  logic par_en;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_idle;
  logic txd;
  logic rxd;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_err;
  modport ctl (output div, par_en, tx_valid, tx_data, rxd,
               input tx_idle, txd, rx_valid, rx_data, rx_err);
  modport phy (input div, par_en, tx_valid, tx_data, rxd,
               output tx_idle, txd, rx_valid, rx_data, rx_err);
endinterface : hps_ser_if

// ==== verilog/hps_uart.sv ====
// Character engine: oversampled transmitter and receiver with parity.
`timescale 1ns/1ns
module hps_uart
  import hps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  hps_ser_if.phy ser
);

  typedef struct packed {
    logic [15:0] tcnt;
    logic tick;
    logic [10:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_ph;
    logic tx_busy;
    logic txd;
    logic rx_busy;
    logic [3:0] rx_ph;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_err;
  } hps_uart_t;

  hps_uart_t r;
  hps_uart_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.tick = 1'b0;
    next_r.rx_valid = 1'b0;
    if (r.tcnt == 16'h0000)
    begin
      next_r.tcnt = ser.div - 16'h0001;
      next_r.tick = 1'b1;
    end
    else
      next_r.tcnt = r.tcnt - 16'h0001;
    // Transmit: start, eight data bits, optional even parity, stop. [R1]
    if (!r.tx_busy && ser.tx_valid)
    begin
      next_r.tx_sh = ser.par_en ? {1'b1, ^ser.tx_data, ser.tx_data, 1'b0}
                                : {2'b11, ser.tx_data, 1'b0};
      next_r.tx_bits = ser.par_en ? 4'hB : 4'hA;
      next_r.tx_ph = 4'h0;
      next_r.tx_busy = 1'b1;
    end
    else if (r.tx_busy && r.tick)
    begin
      next_r.tx_ph = r.tx_ph + 4'h1;
      if (r.tx_ph == 4'hF)
      begin
        next_r.tx_sh = {1'b1, r.tx_sh[10:1]};
        next_r.tx_bits = r.tx_bits - 4'h1;
        if (r.tx_bits == 4'h1)
          next_r.tx_busy = 1'b0;
      end
    end
    next_r.txd = next_r.tx_busy ? next_r.tx_sh[0] : 1'b1;
    // Receive: sample each bit in its middle. [R1]
    if (!r.rx_busy && !ser.rxd)
    begin
      next_r.rx_busy = 1'b1;
      next_r.rx_ph = 4'h0;
      next_r.rx_bits = 4'h0;
    end
    else if (r.rx_busy && r.tick)
    begin
      next_r.rx_ph = r.rx_ph + 4'h1;
      if (r.rx_ph == 4'h7)
      begin
        next_r.rx_bits = r.rx_bits + 4'h1;
        if (r.rx_bits == 4'h0)
          next_r.rx_busy = !ser.rxd;
        else if (r.rx_bits == (ser.par_en ? 4'hA : 4'h9))
        begin
          next_r.rx_busy = 1'b0;
          next_r.rx_valid = 1'b1;
          next_r.rx_data = ser.par_en ? r.rx_sh[7:0] : r.rx_sh[8:1];
          next_r.rx_err = !ser.rxd | (ser.par_en & (^r.rx_sh));
        end
        else
          next_r.rx_sh = {ser.rxd, r.rx_sh[8:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.txd <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign ser.tx_idle = !r.tx_busy;
  assign ser.txd = r.txd;
  assign ser.rx_valid = r.rx_valid;
  assign ser.rx_data = r.rx_data;
  assign ser.rx_err = r.rx_err;

endmodule : hps_uart
